// ==== inc/bor_pkg.sv ====
// Package: constants and types for the brown-out reset controller
package bor_pkg;

   // -----------------------------------------------------------------
   // Modes and power states
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_SW    = 2'h1;
   localparam logic [1:0] MODE_NOSLP = 2'h2;
   localparam logic [1:0] MODE_ON    = 2'h3;

   localparam int SW_EN_BIT = 6;

   typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP} pwr_e;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ           = 125;
   localparam int MIN_DURATION_NS   = 200;
   localparam int MIN_DURATION_CYC  =
      (MIN_DURATION_NS * CLK_MHZ + 999) / 1000;
   localparam int PWRUP_DELAY_US    = 65600;
   localparam int PWRUP_DELAY_CYC   = PWRUP_DELAY_US * CLK_MHZ;
   localparam int CNT_W             = 24;

   // Configuration straps as one carrier
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] threshold;
      logic       powerup_delay_timer_en;
   } bor_cfg_s;

endpackage

// ==== rtl/bor_timer.sv ====
// Down counter used for qualification and power-up delay
`timescale 1ns/1ps
module bor_timer
   import bor_pkg::*;
(
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] value_i,
   output logic                  done_o
);
   logic [CNT_W-1:0] count;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         count <= '0;
      end else if (load_i) begin
         count <= value_i;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign done_o = (count == '0) && !load_i;
endmodule // bor_timer

// ==== rtl/brownout_reset_control.sv ====
// Brown-out reset controller: mode gating, qualification, power-up delay
`timescale 1ns/1ps
module brownout_reset_control
   import bor_pkg::*;
#(
   parameter int PWRUP_CYC = PWRUP_DELAY_CYC
)
(
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   input  wire bor_cfg_s   cfg_i,
   input  wire logic       supply_low_i,
   input  wire logic       sleep_exec_i,
   input  wire logic       wake_i,
   input  wire logic       idle_on_sleep_i,
   input  wire logic       sw_en_wr_i,
   input  wire logic       sw_en_wdata_i,
   input  wire logic       flag_set_i,
   output logic            core_reset_o,
   output logic            brownout_flag_o,
   output logic            sw_brownout_enable_o,
   output logic [1:0]      brownout_threshold_cfg_o,
   output logic            detect_on_o,
   output logic            in_sleep_o
);
   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic low_meta;
   logic low_sync;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         low_meta <= 1'b0;
         low_sync <= 1'b0;
      end else begin
         low_meta <= supply_low_i;
         low_sync <= low_meta;
      end
   end

   // ----------------------------------------------------------------
   // Power mode tracking
   // ----------------------------------------------------------------
   pwr_e pwr;
   pwr_e next_pwr;
   always_comb begin
      next_pwr = pwr;
      if (wake_i)
         next_pwr = PWR_RUN;
      else if (sleep_exec_i)
         next_pwr = idle_on_sleep_i ? PWR_IDLE : PWR_SLEEP;
   end

   // ----------------------------------------------------------------
   // Software enable and mode gating
   // ----------------------------------------------------------------
   logic sw_en;
   logic sw_mode;
   logic next_detect;
   assign sw_mode = (cfg_i.mode == MODE_SW);

   always_comb begin
      unique case (cfg_i.mode)
         MODE_OFF:   next_detect = 1'b0;
         MODE_SW:    next_detect = sw_en;
         MODE_NOSLP: next_detect = (pwr != PWR_SLEEP);
         MODE_ON:    next_detect = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Reset sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_OK, ST_QUAL, ST_BOR, ST_POWERUP_DELAY_TIMER} st_e;
   st_e st;
   st_e next_st;
   logic qual_done;
   logic powerup_delay_timer_done;
   logic qual_load;
   logic powerup_delay_timer_load;

   assign qual_load = (st == ST_OK) && low_sync && next_detect;
   assign powerup_delay_timer_load = (st == ST_BOR) && !low_sync;

   bor_timer u_qual (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .load_i  (qual_load),
      .value_i (CNT_W'(MIN_DURATION_CYC)),
      .done_o  (qual_done)
   );

   bor_timer u_powerup_delay_timer (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .load_i  (powerup_delay_timer_load),
      .value_i (CNT_W'(PWRUP_CYC)),
      .done_o  (powerup_delay_timer_done)
   );

   always_comb begin
      next_st = st;
      unique case (st)
         ST_OK:   if (low_sync && next_detect)
                     next_st = ST_QUAL;
         ST_QUAL: if (!low_sync || !next_detect)
                     next_st = ST_OK;
                  else if (qual_done)
                     next_st = ST_BOR;
         ST_BOR:  if (!low_sync)
                     next_st = cfg_i.powerup_delay_timer_en ? ST_POWERUP_DELAY_TIMER : ST_OK;
         ST_POWERUP_DELAY_TIMER: if (low_sync)
                     next_st = ST_BOR;
                  else if (powerup_delay_timer_done)
                     next_st = ST_OK;
      endcase
   end

   logic next_reset;
   assign next_reset = (next_st == ST_BOR) || (next_st == ST_POWERUP_DELAY_TIMER);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         st                       <= ST_OK;
         pwr                      <= PWR_RUN;
         sw_en                    <= 1'b0;
         core_reset_o             <= 1'b0;
         brownout_flag_o          <= 1'b0;
         sw_brownout_enable_o     <= 1'b0;
         brownout_threshold_cfg_o <= 2'h0;
         detect_on_o              <= 1'b0;
         in_sleep_o               <= 1'b0;
      end else begin
         st           <= next_st;
         pwr          <= next_pwr;
         core_reset_o <= next_reset;
         detect_on_o  <= next_detect;
         in_sleep_o   <= (next_pwr == PWR_SLEEP);
         if (sw_en_wr_i && sw_mode)
            sw_en <= sw_en_wdata_i;
         sw_brownout_enable_o <= sw_mode &&
            (sw_en_wr_i ? sw_en_wdata_i : sw_en);
         brownout_threshold_cfg_o <= cfg_i.threshold;
         // Entering brown-out reset wins over a software set
         if (next_st == ST_BOR && st != ST_BOR)
            brownout_flag_o <= 1'b0;
         else if (flag_set_i)
            brownout_flag_o <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_off_no_reset: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (cfg_i.mode == MODE_OFF && st == ST_OK) |=> !core_reset_o)
      else $error("reset asserted with detection off");
   a_hold_while_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_BOR && low_sync) |=> core_reset_o)
      else $error("reset released while supply low");
   a_powerup_delay_timer_restart: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_POWERUP_DELAY_TIMER && low_sync) |=> st == ST_BOR)
      else $error("low during delay did not return to reset");
   a_sw_reads_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !sw_mode |=> !sw_brownout_enable_o)
      else $error("software enable visible outside mode 01");
   a_always_on: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      cfg_i.mode == MODE_ON |=> detect_on_o)
      else $error("detection off in always-on mode");
   a_sleep_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (cfg_i.mode == MODE_NOSLP && pwr == PWR_SLEEP && !wake_i)
      |=> !detect_on_o)
      else $error("detection on during sleep in mode 10");
   a_flag_clear: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_QUAL && next_st == ST_BOR) |=> !brownout_flag_o)
      else $error("flag not cleared on brown-out");
   a_qual_enter: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_QUAL && low_sync && next_detect && qual_done)
      |=> core_reset_o)
      else $error("qualified low did not reset");
   a_no_powerup_delay_timer: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_BOR && !low_sync && !cfg_i.powerup_delay_timer_en) |=> !core_reset_o)
      else $error("delay applied while timer disabled");
   a_sleep_entry: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (sleep_exec_i && !wake_i && !idle_on_sleep_i) |=> in_sleep_o)
      else $error("sleep not entered");
   a_powerup_delay_timer_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_POWERUP_DELAY_TIMER && !powerup_delay_timer_done) |=> core_reset_o)
      else $error("reset released before delay");

   // ----------------------------------------------------------------
   // Synchroniser and sequencing checks
   // ----------------------------------------------------------------
   // The comparator is asynchronous, so only the second stage is
   // trusted; these pin the two-stage delay that the timing relies on.
   a_meta_follow: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |=> (low_meta == $past(supply_low_i)))
      else $error("first sync stage did not follow comparator");
   a_sync_stage: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |=> (low_sync == $past(low_meta)))
      else $error("second sync stage did not follow first");
   a_ok_stay: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_OK && !(low_sync && next_detect)) |=> st == ST_OK)
      else $error("left idle without a detected low");
   a_ok_to_qual: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_OK && low_sync && next_detect) |=> st == ST_QUAL)
      else $error("detected low did not start qualification");
   a_qual_abort: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_QUAL && (!low_sync || !next_detect)) |=> st == ST_OK)
      else $error("short dip was not dropped");
   a_qual_wait: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_QUAL && low_sync && next_detect && !qual_done)
      |=> st == ST_QUAL)
      else $error("qualification ended early");
   a_bor_stay: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_BOR && low_sync) |=> st == ST_BOR)
      else $error("brown-out state left while supply low");
   a_powerup_delay_timer_enter: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_BOR && !low_sync && cfg_i.powerup_delay_timer_en) |=> st == ST_POWERUP_DELAY_TIMER)
      else $error("power-up delay not started on recovery");
   a_powerup_delay_timer_from_bor: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      $rose(st == ST_POWERUP_DELAY_TIMER) |-> $past(st == ST_BOR))
      else $error("power-up delay entered from wrong state");
   a_powerup_delay_timer_done: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (st == ST_POWERUP_DELAY_TIMER && !low_sync && powerup_delay_timer_done)
      |=> (st == ST_OK && !core_reset_o))
      else $error("reset not released after full delay");
   a_reset_state: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |-> (core_reset_o == (st == ST_BOR || st == ST_POWERUP_DELAY_TIMER)))
      else $error("reset output disagrees with state");

   // ----------------------------------------------------------------
   // Configuration, software and power mode checks
   // ----------------------------------------------------------------
   a_thr_copy: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |=> (brownout_threshold_cfg_o == $past(cfg_i.threshold)))
      else $error("threshold not taken from configuration");
   a_sw_readback: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (sw_mode && !sw_en_wr_i) |=> sw_brownout_enable_o == $past(sw_en))
      else $error("software enable readback wrong");
   a_sw_wr_ignored: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      !sw_mode |=> sw_en == $past(sw_en))
      else $error("software enable changed outside mode 01");
   a_detect_off: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      cfg_i.mode == MODE_OFF |=> !detect_on_o)
      else $error("detection on in mode 00");
   a_detect_sw: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      cfg_i.mode == MODE_SW |=> detect_on_o == $past(sw_en))
      else $error("detection does not follow software enable");
   a_detect_run: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (cfg_i.mode == MODE_NOSLP && pwr != PWR_SLEEP) |=> detect_on_o)
      else $error("detection off while awake in mode 10");
   a_flag_set: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (flag_set_i && !(next_st == ST_BOR && st != ST_BOR))
      |=> brownout_flag_o)
      else $error("software set of flag lost");
   a_flag_hold: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (!flag_set_i && !(next_st == ST_BOR && st != ST_BOR))
      |=> brownout_flag_o == $past(brownout_flag_o))
      else $error("flag changed without cause");
   a_wake_run: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      wake_i |=> (!in_sleep_o && pwr == PWR_RUN))
      else $error("wake did not return to run");
   a_idle_entry: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      (sleep_exec_i && !wake_i && idle_on_sleep_i)
      |=> (!in_sleep_o && pwr == PWR_IDLE))
      else $error("idle not entered");
endmodule // brownout_reset_control

// ==== verification/supply_comparator_model.sv ====
// Behavioural supply comparator that drives the brown-out controller
`timescale 1ns/1ps
module supply_comparator_model (
   input  wire logic mclk_i,
   output logic      supply_low_o
);
   initial supply_low_o = 1'b0;

   // Moves mid-cycle, because the analog comparator knows nothing of mclk
   task automatic set_low(input logic v);
      @(posedge mclk_i);
      #3 supply_low_o = v;
   endtask
endmodule // supply_comparator_model

// ==== verification/brownout_reset_control_test.sv ====
// Self-checking bench for the brown-out reset controller
`timescale 1ns/1ps
module brownout_reset_control_test;
   import bor_pkg::*;
   // Short power-up delay keeps the run brief
   localparam int PW = 50;
   logic       mclk_i = 0;
   logic       nrst_i = 0;
   logic [3:0] pul = '0;
   logic       idle_on_sleep_i = 0;
   logic       sw_en_wdata_i = 0;
   logic       supply_low;
   bor_cfg_s   cfg_i = '0;
   logic       rst_o, flag_o, swen_o, det_o, slp_o;
   logic [1:0] thr_o;
   int         mismatches = 0;
   int         tests_run = 0;
   logic       seen;
   int         n;

   always #4 mclk_i = ~mclk_i;

   supply_comparator_model pm (.mclk_i(mclk_i), .supply_low_o(supply_low));
   brownout_reset_control #(.PWRUP_CYC(PW)) DUT (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
      .supply_low_i(supply_low), .sleep_exec_i(pul[0]), .wake_i(pul[1]),
      .idle_on_sleep_i(idle_on_sleep_i), .sw_en_wr_i(pul[2]),
      .sw_en_wdata_i(sw_en_wdata_i), .flag_set_i(pul[3]),
      .core_reset_o(rst_o), .brownout_flag_o(flag_o),
      .sw_brownout_enable_o(swen_o), .brownout_threshold_cfg_o(thr_o),
      .detect_on_o(det_o), .in_sleep_o(slp_o));

   // ---------------------------------------------
   // Reference model and helpers
   // ---------------------------------------------
   function automatic logic exp_det(logic [1:0] m, logic sw, logic sl);
      return (m == MODE_ON) || (m == MODE_NOSLP && !sl) ||
             (m == MODE_SW && sw);
   endfunction

   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %0d seen %0d", s, e, g);
      end
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic pulse(int k);
      @(posedge mclk_i);
      pul[k] <= 1'b1;
      @(posedge mclk_i);
      pul <= '0;
      tick(2);
   endtask

   task automatic watch(int k, output logic s);
      s = 0;
      repeat (k) begin
         tick(1);
         if (rst_o === 1'b1) s = 1;
      end
   endtask

   task automatic wait_rst(logic v, int k, output int c);
      c = 0;
      while (rst_o !== v) begin
         tick(1);
         c++;
         if (c > k) begin
            chk("reset wait", v, rst_o);
            wrap_up();
         end
      end
   endtask

   task automatic long_dip(output logic s);
      pm.set_low(1'b1);
      watch(40, s);
      pm.set_low(1'b0);
      wait_rst(1'b0, 10, n);
   endtask

   task automatic wrap_up();
      $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'h002e_a91a));
      cfg_i.mode = MODE_ON;
      cfg_i.threshold = 2'($urandom_range(3));
      tick(3);
      chk("reset idle", 0, rst_o);
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      tick(2);
      chk("flag after power-on", 0, flag_o);
      chk("threshold copy", cfg_i.threshold, thr_o);
      pulse(3);
      chk("flag set", 1, flag_o);
      pm.set_low(1'b1);
      wait_rst(1'b1, 40, n);
      chk("qualify delay", 1, n >= MIN_DURATION_CYC);
      chk("flag cleared", 0, flag_o);
      watch(20, seen);
      chk("held while low", 1, rst_o);
      pm.set_low(1'b0);
      wait_rst(1'b0, 6, n);
      repeat (4) begin
         pm.set_low(1'b1);
         tick($urandom_range(1, 15));
         pm.set_low(1'b0);
         watch(40, seen);
         chk("short dip", 0, seen);
      end
      $display("test qualify done");
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge mclk_i);
            cfg_i.mode <= 2'(m);
            sw_en_wdata_i <= s[0];
            pulse(2);
            chk("sw enable", m == 1 && s == 1, swen_o);
            chk("detect", exp_det(2'(m), s[0], 0), det_o);
            long_dip(seen);
            chk("reset by mode", exp_det(2'(m), s[0], 0), seen);
         end
      end
      $display("test modes done");
      for (int m = 2; m < 4; m++) begin
         @(posedge mclk_i);
         cfg_i.mode <= 2'(m);
         idle_on_sleep_i <= 1'b0;
         pulse(0);
         chk("in sleep", 1, slp_o);
         chk("detect asleep", m == 3, det_o);
         long_dip(seen);
         chk("reset asleep", m == 3, seen);
         pulse(1);
         chk("detect awake", 1, det_o);
         @(posedge mclk_i);
         idle_on_sleep_i <= 1'b1;
         pulse(0);
         chk("idle not sleep", 0, slp_o);
         chk("detect idle", 1, det_o);
         pulse(1);
      end
      $display("test sleep done");
      @(posedge mclk_i);
      cfg_i.powerup_delay_timer_en <= 1'b1;
      pm.set_low(1'b1);
      wait_rst(1'b1, 40, n);
      pm.set_low(1'b0);
      tick(PW / 2);
      chk("held in delay", 1, rst_o);
      pm.set_low(1'b1);
      tick(35);
      pm.set_low(1'b0);
      wait_rst(1'b0, PW + 8, n);
      chk("full delay", 1, n >= PW);
      $display("test power-up delay done");
      wrap_up();
   end
endmodule // brownout_reset_control_test
